// >>> src/oaa_core.sv
// Operand addressing sequencer and core registers of the arithmetic unit.
//
// Summary of operation
// - Special registers reached by direct addressing only.
// - Special registers at x0h/x8h are bit-addressable.
// - Direct mode: 8-bit address, RAM or special registers.
// - Indirect mode reaches internal and external RAM.
// - Byte pointer: bank first/second register or stack.
// - Wide pointer is the only 16-bit pointer.
// - Register mode: 3-bit register field in opcode.
// - Register bank chosen from status word bits.
// - Register-specific ops imply accumulator or wide pointer.
// - Immediate operand follows opcode in program memory.
// - Indexed: read program memory at base plus accumulator.
// - Add ops take direct, indirect, register, immediate.
// - Carry joins add-with-carry and subtract-with-borrow.
// - Increment/decrement accumulator, or internal RAM or special register byte in place.
// - Wide pointer increments as one 16-bit step.
// - Product high byte to second register, low to accumulator.
// - Quotient to accumulator, remainder to second register.
// - Decimal fix corrects accumulator after BCD addition.
// - Banks 0-3 sit at RAM bytes 00h-1Fh.
// - RAM bytes 20h-2Fh hold 128 addressable bits.
// - Overflow flag marks signed add/subtract result out of range, nonzero product high byte, or zero divisor.
// - Half carry from bit 3 or no borrow.
`default_nettype none
module oaa_core
   import oaa_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        cmd_valid,
   input  wire oaa_op_e     cmd_op,
   input  wire oaa_mode_e   cmd_mode,
   input  wire logic [7:0]  cmd_addr,
   input  wire oaa_ptr_e    cmd_ptr,
   input  wire oaa_base_e   cmd_base,
   input  wire logic [15:0] instr_pointer,
   input  wire logic [7:0]  stack_top,
   input  wire logic        ld_valid,
   input  wire oaa_ld_e     ld_sel,
   input  wire logic [7:0]  ld_data,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  mem_rdata,
   output logic             cmd_ready,
   output logic             done,
   output logic             bit_value,
   output logic             mem_req,
   output logic             mem_we,
   output oaa_space_e       mem_space,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   output logic [7:0]       accumulator,
   output logic [7:0]       second_reg,
   output logic [7:0]       status_word,
   output logic [15:0]      wide_pointer
);
   typedef struct packed {
      oaa_state_e  st;
      oaa_op_e     op;
      oaa_mode_e   mode;
      logic [2:0]  bit_idx;
      logic [7:0]  acc;
      logic [7:0]  b;
      logic [7:0]  sw;
      logic [15:0] dp;
      logic [7:0]  opnd;
      logic        req;
      logic        we;
      oaa_space_e  space;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        ready;
      logic        done;
      logic        bitv;
   } oaa_core_s;

   oaa_core_s q;
   oaa_core_s q_d;
   oaa_alu_if alu_bus ();

   function automatic logic needs_operand(input oaa_op_e   op,
                                          input oaa_mode_e mode);
      case (op)
         OP_SUM, OP_SUM_CARRY, OP_MINUS_BORROW: return 1'b1;
         OP_LOOKUP, OP_BIT_READ: return 1'b1;
         OP_BUMP_UP, OP_BUMP_DOWN: return mode != MODE_SPECIFIC;
         default: return 1'b0;
      endcase
   endfunction : needs_operand

   // Bank registers live at 00h-1Fh, eight bytes per bank.
   function automatic logic [15:0] bank_addr(input logic [7:0] sw,
                                             input logic [2:0] idx);
      return {BYTE_ZERO, 3'b000, sw[SW_BANK_HI], sw[SW_BANK_LO], idx};
   endfunction : bank_addr

   oaa_alu oaa_alu_i (
      .alu (alu_bus.alu)
   );

   // A memory byte is the bump source only when the mode is not implied.
   assign alu_bus.op    = q.op;
   assign alu_bus.a     = ((q.op == OP_BUMP_UP || q.op == OP_BUMP_DOWN) &&
                           q.mode != MODE_SPECIFIC) ? q.opnd : q.acc;
   assign alu_bus.b_in  = q.b;
   assign alu_bus.opnd  = q.opnd;
   assign alu_bus.cf_in = q.sw[SW_CARRY];
   assign alu_bus.hf_in = q.sw[SW_HALF];

   always_comb begin
      q_d      = q;
      q_d.done = 1'b0;
      case (q.st)
         ST_IDLE: begin
            if (cmd_valid) begin
               q_d.op      = cmd_op;
               q_d.mode    = cmd_mode;
               q_d.bit_idx = cmd_addr[2:0];
               q_d.ready   = 1'b0;
               q_d.req     = 1'b1;
               q_d.we      = 1'b0;
               q_d.space   = SPACE_IRAM;
               q_d.st      = ST_OPND;
               if (!needs_operand(cmd_op, cmd_mode)) begin
                  q_d.req = 1'b0;
                  q_d.st  = ST_EXEC;
               end else if (cmd_op == OP_BIT_READ) begin
                  if (cmd_addr < SPECIAL_BASE) begin
                     q_d.addr = {BYTE_ZERO,
                                 BIT_RAM_BASE + {4'h0, cmd_addr[6:3]}};
                  end else begin
                     q_d.space = SPACE_SPECIAL;
                     q_d.addr  = {BYTE_ZERO, cmd_addr[7:3], BIT_SPEC_LOW};
                  end
               end else if (cmd_op == OP_LOOKUP ||
                            cmd_mode == MODE_INDEXED) begin
                  q_d.space = SPACE_CODE;
                  q_d.addr  = ((cmd_base == BASE_INSTR) ? instr_pointer
                               : q.dp) + {BYTE_ZERO, q.acc};
               end else begin
                  case (cmd_mode)
                     MODE_DIRECT: begin
                        if (cmd_addr >= SPECIAL_BASE) begin
                           q_d.space = SPACE_SPECIAL;
                        end
                        q_d.addr = {BYTE_ZERO, cmd_addr};
                     end
                     MODE_INDIRECT: begin
                        case (cmd_ptr)
                           PTR_WIDE: begin
                              q_d.space = SPACE_XRAM;
                              q_d.addr  = q.dp;
                           end
                           PTR_STACK: begin
                              q_d.addr = {BYTE_ZERO, stack_top};
                           end
                           default: begin
                              q_d.addr = bank_addr(q.sw,
                                                   {2'b00, cmd_ptr[0]});
                              q_d.st   = ST_PTR;
                           end
                        endcase
                     end
                     MODE_REGISTER: begin
                        q_d.addr = bank_addr(q.sw, cmd_addr[2:0]);
                     end
                     MODE_IMMEDIATE: begin
                        q_d.space = SPACE_CODE;
                        q_d.addr  = instr_pointer + WORD_ONE;
                     end
                     default: begin
                        // An implied operand for an add is the accumulator.
                        q_d.req  = 1'b0;
                        q_d.opnd = q.acc;
                        q_d.st   = ST_EXEC;
                     end
                  endcase
               end
            end else if (ld_valid) begin
               case (ld_sel)
                  LD_ACC:    q_d.acc      = ld_data;
                  LD_SECOND: q_d.b        = ld_data;
                  LD_STATUS: q_d.sw       = ld_data;
                  LD_PTR_LO: q_d.dp[7:0]  = ld_data;
                  LD_PTR_HI: q_d.dp[15:8] = ld_data;
                  default:   q_d.acc      = q.acc;
               endcase
            end
         end
         ST_PTR: begin
            if (mem_ack) begin
               q_d.addr = {BYTE_ZERO, mem_rdata};
               q_d.st   = ST_OPND;
            end
         end
         ST_OPND: begin
            if (mem_ack) begin
               q_d.opnd = mem_rdata;
               q_d.req  = 1'b0;
               q_d.st   = ST_EXEC;
            end
         end
         ST_EXEC: begin
            q_d.st    = ST_IDLE;
            q_d.ready = 1'b1;
            q_d.done  = 1'b1;
            case (q.op)
               OP_BUMP_UP, OP_BUMP_DOWN: begin
                  if (q.mode == MODE_SPECIFIC) begin
                     q_d.acc = alu_bus.res;
                  end else if (q.space == SPACE_IRAM ||
                               q.space == SPACE_SPECIAL) begin
                     // The byte goes back where it came from.
                     q_d.req   = 1'b1;
                     q_d.we    = 1'b1;
                     q_d.wdata = alu_bus.res;
                     q_d.st    = ST_WB;
                     q_d.ready = 1'b0;
                     q_d.done  = 1'b0;
                  end
               end
               OP_PTR_BUMP: q_d.dp = q.dp + WORD_ONE;
               OP_LOOKUP:   q_d.acc = q.opnd;
               OP_BIT_READ: q_d.bitv = q.opnd[q.bit_idx];
               default: begin
                  q_d.acc = alu_bus.res;
                  q_d.b   = alu_bus.res_b;
               end
            endcase
            if (alu_bus.upd_cf) q_d.sw[SW_CARRY] = alu_bus.cf;
            if (alu_bus.upd_hf) q_d.sw[SW_HALF] = alu_bus.hf;
            if (alu_bus.upd_vf) q_d.sw[SW_OVFL] = alu_bus.vf;
         end
         ST_WB: begin
            if (mem_ack) begin
               q_d.req   = 1'b0;
               q_d.we    = 1'b0;
               q_d.done  = 1'b1;
               q_d.ready = 1'b1;
               q_d.st    = ST_IDLE;
            end
         end
         default: begin
            q_d.st = ST_IDLE;
         end
      endcase
      q_d.sw[SW_P] = ^q_d.acc;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q       <= '0;
         q.ready <= 1'b1;
      end else begin
         q <= q_d;
      end
   end

   assign cmd_ready    = q.ready;
   assign done         = q.done;
   assign bit_value    = q.bitv;
   assign mem_req      = q.req;
   assign mem_we       = q.we;
   assign mem_space    = q.space;
   assign mem_addr     = q.addr;
   assign mem_wdata    = q.wdata;
   assign accumulator  = q.acc;
   assign second_reg   = q.b;
   assign status_word  = q.sw;
   assign wide_pointer = q.dp;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_special_direct;
      (q.req && q.space == SPACE_SPECIAL) |->
         (q.mode == MODE_DIRECT || q.op == OP_BIT_READ) && q.addr[7];
   endproperty
   a_special_direct: assert property (p_special_direct)
      else $error("special space reached without direct address");

   property p_bit_spec_aligned;
      (q.req && q.op == OP_BIT_READ && q.space == SPACE_SPECIAL) |->
         q.addr[2:0] == BIT_SPEC_LOW;
   endproperty
   a_bit_spec_aligned: assert property (p_bit_spec_aligned)
      else $error("bit access to unaligned special register");

   property p_bit_ram_byte;
      (q.req && q.op == OP_BIT_READ && q.space == SPACE_IRAM) |->
         q.addr[15:4] == {BYTE_ZERO, BIT_RAM_BASE[7:4]};
   endproperty
   a_bit_ram_byte: assert property (p_bit_ram_byte)
      else $error("bit access outside bit RAM bytes");

   property p_reg_bank;
      (q.st == ST_IDLE && cmd_valid && cmd_mode == MODE_REGISTER &&
       cmd_op inside {OP_SUM, OP_SUM_CARRY, OP_MINUS_BORROW}) |=>
         q.addr == {BYTE_ZERO, 3'b000, $past(q.sw[SW_BANK_HI]),
                    $past(q.sw[SW_BANK_LO]), $past(cmd_addr[2:0])};
   endproperty
   a_reg_bank: assert property (p_reg_bank)
      else $error("register operand from wrong bank address");

   property p_wide_xram;
      (q.req && q.space == SPACE_XRAM) |->
         q.mode == MODE_INDIRECT && q.addr == q.dp;
   endproperty
   a_wide_xram: assert property (p_wide_xram)
      else $error("external access not through wide pointer");

   property p_code_read_only;
      (q.req && q.space == SPACE_CODE) |-> !q.we ##1 !q.we;
   endproperty
   a_code_read_only: assert property (p_code_read_only)
      else $error("write toward program memory");

   property p_sum_carry;
      (q.st == ST_EXEC && q.op == OP_SUM_CARRY) |=>
         q.acc == 8'($past(q.acc) + $past(q.opnd) +
                     {7'h00, $past(q.sw[SW_CARRY])});
   endproperty
   a_sum_carry: assert property (p_sum_carry)
      else $error("add with carry result wrong");

   property p_product;
      (q.st == ST_EXEC && q.op == OP_PRODUCT) |=>
         {q.b, q.acc} == {BYTE_ZERO, $past(q.acc)} *
                         {BYTE_ZERO, $past(q.b)};
   endproperty
   a_product: assert property (p_product)
      else $error("product placed wrongly");

   property p_quotient;
      (q.st == ST_EXEC && q.op == OP_QUOTIENT && q.b != BYTE_ZERO) |=>
         q.acc == $past(q.acc) / $past(q.b) &&
         q.b == $past(q.acc) % $past(q.b) && !q.sw[SW_OVFL];
   endproperty
   a_quotient: assert property (p_quotient)
      else $error("quotient or remainder wrong");

   property p_zero_divide;
      (q.st == ST_EXEC && q.op == OP_QUOTIENT && q.b == BYTE_ZERO) |=>
         q.sw[SW_OVFL] && $stable(q.b) && q.done;
   endproperty
   a_zero_divide: assert property (p_zero_divide)
      else $error("zero divide not flagged");

   property p_ptr_bump;
      (q.st == ST_EXEC && q.op == OP_PTR_BUMP) |=>
         q.dp == $past(q.dp) + WORD_ONE;
   endproperty
   a_ptr_bump: assert property (p_ptr_bump)
      else $error("wide pointer increment wrong");

   c_product:  cover property (q.st == ST_EXEC && q.op == OP_PRODUCT);
   c_pointer:  cover property (q.st == ST_PTR && mem_ack);
   c_write_bk: cover property (q.st == ST_WB && mem_ack);
endmodule : oaa_core
`default_nettype wire

// >>> src/oaa_pkg.sv
// Shared constants and types of the operand addressing arithmetic unit.
`default_nettype none
package oaa_pkg;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 16;
   localparam logic [7:0]  SPECIAL_BASE = 8'h80;
   localparam logic [7:0]  BIT_RAM_BASE = 8'h20;
   localparam logic [2:0]  BIT_SPEC_LOW = 3'h0;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [7:0]  BYTE_ONE     = 8'h01;
   localparam logic [15:0] WORD_ONE     = 16'h0001;
   localparam logic [3:0]  BCD_MAX      = 4'h9;
   localparam logic [7:0]  BCD_LO_FIX   = 8'h06;
   localparam logic [7:0]  BCD_HI_FIX   = 8'h60;
   localparam int          SW_CARRY     = 7;
   localparam int          SW_HALF      = 6;
   localparam int          SW_BANK_HI   = 4;
   localparam int          SW_BANK_LO   = 3;
   localparam int          SW_OVFL      = 2;
   localparam int          SW_P         = 0;

   typedef enum logic [3:0] {
      OP_SUM, OP_SUM_CARRY, OP_MINUS_BORROW, OP_BUMP_UP, OP_BUMP_DOWN,
      OP_PTR_BUMP, OP_PRODUCT, OP_QUOTIENT, OP_DECIMAL_FIX, OP_LOOKUP,
      OP_BIT_READ
   } oaa_op_e;

   typedef enum logic [2:0] {
      MODE_DIRECT, MODE_INDIRECT, MODE_REGISTER, MODE_SPECIFIC,
      MODE_IMMEDIATE, MODE_INDEXED
   } oaa_mode_e;

   typedef enum logic [1:0] {
      PTR_FIRST, PTR_SECOND, PTR_STACK, PTR_WIDE
   } oaa_ptr_e;

   typedef enum logic {BASE_WIDE, BASE_INSTR} oaa_base_e;

   typedef enum logic [1:0] {
      SPACE_IRAM, SPACE_SPECIAL, SPACE_XRAM, SPACE_CODE
   } oaa_space_e;

   typedef enum logic [2:0] {
      LD_ACC, LD_SECOND, LD_STATUS, LD_PTR_LO, LD_PTR_HI
   } oaa_ld_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PTR  = 3'b001,
      ST_OPND = 3'b011,
      ST_EXEC = 3'b010,
      ST_WB   = 3'b110
   } oaa_state_e;
endpackage : oaa_pkg
`default_nettype wire

// >>> src/oaa_alu_if.sv
// Signals passed between the sequencer and the arithmetic unit.
`default_nettype none
interface oaa_alu_if;
   import oaa_pkg::*;
   oaa_op_e    op;
   logic [7:0] a;
   logic [7:0] b_in;
   logic [7:0] opnd;
   logic       cf_in;
   logic       hf_in;
   logic [7:0] res;
   logic [7:0] res_b;
   logic       cf;
   logic       hf;
   logic       vf;
   logic       upd_cf;
   logic       upd_hf;
   logic       upd_vf;
   modport core (output op, a, b_in, opnd, cf_in, hf_in,
                 input res, res_b, cf, hf, vf, upd_cf, upd_hf, upd_vf);
   modport alu (input op, a, b_in, opnd, cf_in, hf_in,
                output res, res_b, cf, hf, vf, upd_cf, upd_hf, upd_vf);
endinterface : oaa_alu_if
`default_nettype wire

// >>> src/oaa_alu.sv
// Combinational byte arithmetic with flag generation.
`default_nettype none
module oaa_alu
   import oaa_pkg::*;
#(
   parameter int unsigned WIDTH = DATA_W
) (
   oaa_alu_if.alu alu
);
   if (WIDTH != DATA_W) begin : g_bad_width
      $error("oaa_alu supports only byte operands");
   end

   // Returns {carry, half carry, overflow, result}.
   function automatic logic [10:0] add_flags(input logic [7:0] x,
                                             input logic [7:0] y,
                                             input logic       cin,
                                             input logic       sub);
      logic [4:0] lo;
      logic [8:0] full;
      logic       hf;
      logic       vf;
      if (sub) begin
         lo   = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
         full = {1'b0, x} - {1'b0, y} - {8'h00, cin};
         hf   = ~lo[4];
         vf   = (x[7] ^ y[7]) & (x[7] ^ full[7]);
      end else begin
         lo   = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
         full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
         hf   = lo[4];
         vf   = ~(x[7] ^ y[7]) & (x[7] ^ full[7]);
      end
      return {full[8], hf, vf, full[7:0]};
   endfunction : add_flags

   logic [10:0] f;
   logic [15:0] p;
   logic [8:0]  d;

   always_comb begin
      f          = '0;
      p          = '0;
      d          = '0;
      alu.res    = alu.a;
      alu.res_b  = alu.b_in;
      alu.cf     = 1'b0;
      alu.hf     = 1'b0;
      alu.vf     = 1'b0;
      alu.upd_cf = 1'b0;
      alu.upd_hf = 1'b0;
      alu.upd_vf = 1'b0;
      case (alu.op)
         OP_SUM, OP_SUM_CARRY, OP_MINUS_BORROW: begin
            f = add_flags(alu.a, alu.opnd,
                          (alu.op != OP_SUM) & alu.cf_in,
                          alu.op == OP_MINUS_BORROW);
            {alu.cf, alu.hf, alu.vf, alu.res} = f;
            alu.upd_cf = 1'b1;
            alu.upd_hf = 1'b1;
            alu.upd_vf = 1'b1;
         end
         OP_BUMP_UP, OP_BUMP_DOWN: begin
            f = add_flags(alu.a, BYTE_ONE, 1'b0, alu.op == OP_BUMP_DOWN);
            alu.res = f[7:0];
         end
         OP_PRODUCT: begin
            p          = {BYTE_ZERO, alu.a} * {BYTE_ZERO, alu.b_in};
            alu.res    = p[7:0];
            alu.res_b  = p[15:8];
            alu.vf     = p[15:8] != BYTE_ZERO;
            alu.upd_cf = 1'b1;
            alu.upd_vf = 1'b1;
         end
         OP_QUOTIENT: begin
            // A zero divisor leaves both registers untouched.
            if (alu.b_in == BYTE_ZERO) begin
               alu.vf = 1'b1;
            end else begin
               alu.res   = alu.a / alu.b_in;
               alu.res_b = alu.a % alu.b_in;
            end
            alu.upd_cf = 1'b1;
            alu.upd_vf = 1'b1;
         end
         OP_DECIMAL_FIX: begin
            // Only meaningful right after adding two packed BCD bytes.
            d = {1'b0, alu.a};
            if (alu.hf_in || d[3:0] > BCD_MAX) begin
               d = d + {1'b0, BCD_LO_FIX};
            end
            if (alu.cf_in || d[8] || d[7:4] > BCD_MAX) begin
               d = d + {1'b0, BCD_HI_FIX};
            end
            alu.res    = d[7:0];
            alu.cf     = alu.cf_in | d[8];
            alu.upd_cf = 1'b1;
         end
         default: begin
            alu.res = alu.a;
         end
      endcase
   end
endmodule : oaa_alu
`default_nettype wire

// >>> sim/oaa_mem_model.sv
// Behavioural memory answering the core's byte accesses.
`default_nettype none
module oaa_mem_model
   import oaa_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire oaa_space_e  mem_space,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic [1:0]  slow,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] iram [256];
   logic [1:0] wait_q;
   initial mem_rdata = 8'h00;
   always @(posedge sys_clk) begin
      if (reset || mem_ack || !mem_req) begin
         mem_ack <= 1'b0;
         wait_q  <= 2'h0;
         // Stale read data flips so it can never pass for a fresh answer.
         mem_rdata <= ~mem_rdata;
      end else if (wait_q == slow) begin
         mem_ack <= 1'b1;
         case (mem_space)
            SPACE_IRAM:    mem_rdata <= iram[mem_addr[7:0]];
            SPACE_SPECIAL: mem_rdata <= ~mem_addr[7:0];
            SPACE_XRAM:    mem_rdata <= mem_addr[15:8] + mem_addr[7:0];
            default:       mem_rdata <= mem_addr[7:0] ^ 8'h5a;
         endcase
         if (mem_we && mem_space == SPACE_IRAM) begin
            iram[mem_addr[7:0]] <= mem_wdata;
         end
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule : oaa_mem_model
`default_nettype wire

// >>> sim/tb_operand_addressing_arith_unit.sv
// Self-checking bench of the operand addressing arithmetic unit.
`default_nettype none
module tb_operand_addressing_arith_unit
   import oaa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, reset, cmd_valid, ld_valid, mem_ack;
   logic        cmd_ready, done, bit_value, mem_req, mem_we;
   logic [7:0]  cmd_addr, stack_top, ld_data, mem_rdata, mem_wdata;
   logic [7:0]  accumulator, second_reg, status_word;
   logic [15:0] instr_pointer, mem_addr, wide_pointer;
   logic [1:0]  slow;
   oaa_op_e     cmd_op;
   oaa_mode_e   cmd_mode;
   oaa_ptr_e    cmd_ptr;
   oaa_base_e   cmd_base;
   oaa_ld_e     ld_sel;
   oaa_space_e  mem_space;
   int          error_cnt, checked;

   always #50 sys_clk = ~sys_clk;

   oaa_core oaa_core_i (.sys_clk, .reset, .cmd_valid, .cmd_op, .cmd_mode,
      .cmd_addr, .cmd_ptr, .cmd_base, .instr_pointer, .stack_top, .ld_valid,
      .ld_sel, .ld_data, .mem_ack, .mem_rdata, .cmd_ready, .done, .bit_value,
      .mem_req, .mem_we, .mem_space, .mem_addr, .mem_wdata, .accumulator,
      .second_reg, .status_word, .wide_pointer);
   oaa_mem_model oaa_mem_model_i (.sys_clk, .reset, .mem_req, .mem_we,
      .mem_space, .mem_addr, .mem_wdata, .slow, .mem_ack, .mem_rdata);

   task automatic finish_test;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic load(input oaa_ld_e s, input logic [7:0] d);
      @(posedge sys_clk);
      ld_valid <= 1'b1;
      ld_sel   <= s;
      ld_data  <= d;
      @(posedge sys_clk);
      ld_valid <= 1'b0;
   endtask : load

   // Holds the request one edge; cmd_ready is high whenever this is entered.
   task automatic run(input oaa_op_e op, input oaa_mode_e m = MODE_DIRECT,
                      input logic [7:0] a = 8'h00,
                      input oaa_ptr_e p = PTR_FIRST,
                      input oaa_base_e b = BASE_WIDE);
      int n;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_mode  <= m;
      cmd_addr  <= a;
      cmd_ptr   <= p;
      cmd_base  <= b;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      #1;
      for (n = 0; n < 40 && done !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      if (done !== 1'b1) begin
         chk("done", 8'h01, {7'h00, done});
         finish_test;
      end
   endtask : run

   task automatic t_add;
      oaa_mem_model_i.iram[8'h10] = 8'h01;
      load(LD_ACC, 8'h7f);
      load(LD_STATUS, 8'h00);
      run(OP_SUM, MODE_DIRECT, 8'h10);
      chk("acc", 8'h80, accumulator);
      chk("flags", 8'h44, status_word & 8'hc4);
      load(LD_STATUS, 8'h80);
      run(OP_SUM_CARRY, MODE_DIRECT, 8'ha0);
      chk("acc", 8'he0, accumulator);
      chk("flags", 8'h40, status_word & 8'hc4);
   endtask : t_add

   task automatic t_sub;
      oaa_mem_model_i.iram[8'h15] = 8'h20;
      slow <= 2'h2;
      load(LD_ACC, 8'h50);
      load(LD_STATUS, 8'h90);
      run(OP_MINUS_BORROW, MODE_REGISTER, 8'h05);
      chk("acc", 8'h2f, accumulator);
      chk("flags", 8'h00, status_word & 8'hc4);
      load(LD_ACC, 8'h00);
      run(OP_MINUS_BORROW, MODE_REGISTER, 8'h05);
      chk("acc", 8'he0, accumulator);
      chk("flags", 8'hc0, status_word & 8'hc4);
      slow <= 2'h0;
   endtask : t_sub

   task automatic t_ind;
      oaa_mem_model_i.iram[8'h01] = 8'h30;
      oaa_mem_model_i.iram[8'h30] = 8'h05;
      load(LD_STATUS, 8'h00);
      load(LD_ACC, 8'h00);
      run(OP_SUM, MODE_INDIRECT, 8'h00, PTR_SECOND);
      chk("acc", 8'h05, accumulator);
      run(OP_SUM, MODE_INDIRECT, 8'h00, PTR_STACK);
      chk("acc", 8'h0a, accumulator);
      load(LD_PTR_LO, 8'h34);
      load(LD_PTR_HI, 8'h12);
      run(OP_SUM, MODE_INDIRECT, 8'h00, PTR_WIDE);
      chk("acc", 8'h50, accumulator);
   endtask : t_ind

   task automatic t_imm;
      load(LD_ACC, 8'h00);
      run(OP_SUM, MODE_IMMEDIATE);
      chk("acc", 8'h5b, accumulator);
      run(OP_LOOKUP, MODE_INDEXED, 8'h00, PTR_FIRST, BASE_INSTR);
      chk("acc", 8'h01, accumulator);
      run(OP_LOOKUP, MODE_INDEXED);
      chk("acc", 8'h6f, accumulator);
   endtask : t_imm

   task automatic t_bump;
      oaa_mem_model_i.iram[8'h40] = 8'h00;
      load(LD_ACC, 8'h33);
      run(OP_BUMP_DOWN, MODE_DIRECT, 8'h40);
      chk("byte", 8'hff, oaa_mem_model_i.iram[8'h40]);
      chk("acc", 8'h33, accumulator);
      run(OP_BUMP_UP, MODE_SPECIFIC);
      chk("acc", 8'h34, accumulator);
      load(LD_PTR_LO, 8'hff);
      load(LD_PTR_HI, 8'h00);
      run(OP_PTR_BUMP, MODE_SPECIFIC);
      chk("ptr_hi", 8'h01, wide_pointer[15:8]);
      chk("ptr_lo", 8'h00, wide_pointer[7:0]);
   endtask : t_bump

   task automatic t_muldiv;
      load(LD_ACC, 8'hc8);
      load(LD_SECOND, 8'h02);
      load(LD_STATUS, 8'h00);
      run(OP_PRODUCT, MODE_SPECIFIC);
      chk("hi", 8'h01, second_reg);
      chk("lo", 8'h90, accumulator);
      chk("flags", 8'h04, status_word & 8'h84);
      load(LD_SECOND, 8'h0a);
      run(OP_QUOTIENT, MODE_SPECIFIC);
      chk("quot", 8'h0e, accumulator);
      chk("rem", 8'h04, second_reg);
      chk("flags", 8'h00, status_word & 8'h84);
      load(LD_SECOND, 8'h00);
      run(OP_QUOTIENT, MODE_SPECIFIC);
      chk("flags", 8'h04, status_word & 8'h84);
   endtask : t_muldiv

   task automatic t_bcd_bit;
      oaa_mem_model_i.iram[8'h10] = 8'h28;
      oaa_mem_model_i.iram[8'h2c] = 8'h08;
      load(LD_ACC, 8'h19);
      load(LD_STATUS, 8'h00);
      run(OP_SUM, MODE_DIRECT, 8'h10);
      run(OP_DECIMAL_FIX, MODE_SPECIFIC);
      chk("bcd", 8'h47, accumulator);
      run(OP_BIT_READ, MODE_DIRECT, 8'h63);
      chk("bit", 8'h01, {7'h00, bit_value});
      run(OP_BIT_READ, MODE_DIRECT, 8'h64);
      chk("bit", 8'h00, {7'h00, bit_value});
      run(OP_BIT_READ, MODE_DIRECT, 8'h88);
      chk("bit", 8'h01, {7'h00, bit_value});
      run(OP_BIT_READ, MODE_DIRECT, 8'h8b);
      chk("bit", 8'h00, {7'h00, bit_value});
   endtask : t_bcd_bit

   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      cmd_valid = 1'b0;
      ld_valid = 1'b0;
      cmd_op = OP_SUM;
      cmd_mode = MODE_DIRECT;
      cmd_addr = 8'h00;
      cmd_ptr = PTR_FIRST;
      cmd_base = BASE_WIDE;
      instr_pointer = 16'h1000;
      stack_top = 8'h30;
      ld_sel = LD_ACC;
      ld_data = 8'h00;
      slow = 2'h0;
      error_cnt = 0;
      checked = 0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      chk("status", 8'h00, status_word);
      chk("ready", 8'h01, {7'h00, cmd_ready});
      t_add;
      t_sub;
      t_ind;
      t_imm;
      t_bump;
      t_muldiv;
      t_bcd_bit;
      finish_test;
   end
endmodule : tb_operand_addressing_arith_unit
`default_nettype wire
